// ---- rtl/hsef_status.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hsef_map.svh"
module hsef_status
  import hsef_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic proto_chunk,
  input wire logic cut_through_en,
  input wire logic phy_irq_src,
  input wire logic phy_irq_ack,
  input wire logic reset_complete_evt,
  input wire logic ctrl_protect_fail,
  input wire logic rx_buf_overflow_evt,
  input wire logic tx_underrun_evt,
  input wire logic chunk_strobe,
  input wire logic chunk_data_valid,
  input wire logic chunk_start_valid,
  input wire logic chunk_end_valid,
  input wire logic tx_frame_size_reg_wr,
  input wire logic [`HSEF_FSIZE_W-1:0] tx_frame_size_reg_val,
  input wire logic tx_data_wr,
  input wire logic tx_wr,
  input wire logic tx_wr_sof,
  input wire logic tx_fifo_full,
  input wire logic [`HSEF_SPACE_W-1:0] tx_free_space,
  output logic tx_wr_accept,
  output logic tx_frame_discard,
  output logic tx_abort,
  output logic [7:0] tx_credit_field,
  output logic [`HSEF_SPACE_W-1:0] tx_space,
  output logic extended_status_ind,
  output logic irq_out_n
);
  logic [2:0] pins_sync;
  logic sclk_s, cs_n_s, mosi_s;
  logic sclk_d, cs_n_d;
  logic sclk_rise, sclk_fall, cs_rise;
  logic [5:0] bit_cnt;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [31:0] wdata;
  logic [31:0] rd_shift;
  logic host_wr;
  logic [31:0] host_wdata;
  logic hdr_ok;
  logic hdr_bad_evt;
  logic early_cs_evt;
  logic [12:0] set_vec;
  logic [12:0] clr_vec;
  logic [12:0] flags;
  logic phy_bit, por_flag, por_seen;
  logic [31:0] irq_mask;
  logic [31:0] status_word;
  logic [31:0] rd_data;
  logic drop_frame;
  logic ovf_evt;
  hsef_chunk_state_type chunk_state;
  logic chunk_err, fsize_err;
  logic [`HSEF_FSIZE_W-1:0] fsize_left;

  // Pins come from the host's domain, so they are synchronised first.
  // Chip select idles high, so its stages reset high and the output enable stays low.
  hsef_sync #(.WIDTH(3), .RESET_VAL(3'b010)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({spi_sclk, spi_cs_n, spi_mosi}),
    .sync_out(pins_sync)
  );
  assign sclk_s = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // Delayed copies for edge detection.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_n_d;
  assign next_cmd = {cmd[6:0], mosi_s};
  // Odd parity over the whole command byte; only enforced under the chunk protocol.
  assign hdr_ok = ~proto_chunk | (^cmd);
  assign hdr_bad_evt = sclk_rise & (bit_cnt == `HSEF_CMD_BITS - 6'd1) & proto_chunk & ~(^next_cmd);
  assign early_cs_evt = cs_rise & (bit_cnt != 6'd0) & (bit_cnt != `HSEF_FRAME_BITS);
  assign host_wdata = {wdata[30:0], mosi_s};
  assign host_wr = sclk_rise & (bit_cnt == `HSEF_FRAME_BITS - 6'd1) & cmd[7] & hdr_ok;

  // Frame shifter: command byte then one 32-bit word, sampled on rising clock.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 6'd0;
      cmd <= 8'h00;
      wdata <= 32'h00000000;
    end else if (cs_n_s) begin
      bit_cnt <= 6'd0;
    end else if (sclk_rise && bit_cnt < `HSEF_FRAME_BITS) begin
      bit_cnt <= bit_cnt + 6'd1;
      if (bit_cnt < `HSEF_CMD_BITS) begin
        cmd <= next_cmd;
      end else begin
        wdata <= host_wdata;
      end
    end
  end

  // Read data is captured once the address is known and shifted out on falling edges.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_shift <= 32'h00000000;
      spi_miso <= 1'b0;
    end else if (sclk_rise && bit_cnt == `HSEF_CMD_BITS - 6'd1) begin
      rd_shift <= rd_data;
    end else if (sclk_fall && bit_cnt >= `HSEF_CMD_BITS && bit_cnt < `HSEF_FRAME_BITS) begin
      spi_miso <= rd_shift[31];
      rd_shift <= {rd_shift[30:0], 1'b0};
    end
  end
  assign spi_miso_oe = ~cs_n_s;

  // Read mux; unmapped addresses return zero.
  always_comb begin
    case (next_cmd[5:0])
      `HSEF_ADDR_STATUS: rd_data = status_word;
      `HSEF_ADDR_MASK: rd_data = irq_mask;
      default: rd_data = 32'h00000000;
    endcase
  end

  // Interrupt enables; the PHY summary is disabled out of reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= `HSEF_MASK_RESET;
    end else if (host_wr && cmd[5:0] == `HSEF_ADDR_MASK) begin
      irq_mask <= host_wdata;
    end
  end

  // Event sources for each sticky flag.
  always_comb begin
    set_vec = 13'h0000;
    set_vec[`HSEF_BIT_CDP] = ctrl_protect_fail & proto_chunk;
    set_vec[`HSEF_BIT_RSTDONE] = reset_complete_evt;
    set_vec[`HSEF_BIT_HDR] = hdr_bad_evt;
    set_vec[`HSEF_BIT_LOF] = early_cs_evt | (ctrl_protect_fail & proto_chunk);
    set_vec[`HSEF_BIT_RXOVF] = rx_buf_overflow_evt;
    set_vec[`HSEF_BIT_TXUND] = tx_underrun_evt & cut_through_en;
    set_vec[`HSEF_BIT_TXOVF] = ovf_evt;
    set_vec[`HSEF_BIT_TXSEQ] = proto_chunk ? chunk_err : fsize_err;
  end

  // Writing a one clears; zeros and non-flag bits are ignored.
  assign clr_vec = (host_wr && cmd[5:0] == `HSEF_ADDR_STATUS) ? host_wdata[12:0] : 13'h0000;

  // One sticky cell per flag bit; other positions read zero.
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_flag
      localparam logic [12:0] FLAG_BITS = `HSEF_W1C_BITS;
      localparam logic [31:0] RST_WORD = `HSEF_STATUS_RESET;
      if (FLAG_BITS[gi]) begin : g_cell
        hsef_w1c_flag #(.RESET_VAL(RST_WORD[gi])) u_flag (
          .ref_clk(ref_clk),
          .rst(rst),
          .set_evt(set_vec[gi]),
          .clr_wr(clr_vec[gi]),
          .flag(flags[gi])
        );
      end else begin : g_none
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // The PHY bit is forced on after reset release until the host acknowledges via MDIO.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      por_seen <= 1'b0;
      por_flag <= 1'b0;
      phy_bit <= 1'b0;
    end else begin
      por_seen <= 1'b1;
      if (!por_seen) begin
        por_flag <= 1'b1;
      end else if (phy_irq_ack) begin
        por_flag <= 1'b0;
      end
      phy_bit <= phy_irq_src | por_flag;
    end
  end

  // Status word; during reset this reads 0x40.
  assign status_word = {19'h00000, flags[12], 4'h0, phy_bit, flags[6:0]};
  assign extended_status_ind = flags[`HSEF_BIT_RSTDONE];

  // Interrupt pin; reset-done cannot be masked.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(flags[`HSEF_BIT_RSTDONE] | (|(status_word & irq_mask)));
    end
  end

  // Overflow drops the frame and locks out writes until a start of frame.
  assign ovf_evt = tx_wr & tx_fifo_full;
  assign tx_wr_accept = tx_wr & ~tx_fifo_full & (~drop_frame | tx_wr_sof);
  assign tx_frame_discard = ovf_evt;
  assign tx_abort = tx_underrun_evt & cut_through_en;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drop_frame <= 1'b0;
    end else if (ovf_evt) begin
      drop_frame <= 1'b1;
    end else if (tx_wr && tx_wr_sof) begin
      drop_frame <= 1'b0;
    end
  end

  // Free space is reported both as chunk credits and as a byte count.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_credit_field <= 8'h00;
      tx_space <= '0;
    end else begin
      tx_credit_field <= 8'(tx_free_space >> `HSEF_CREDIT_SHIFT);
      tx_space <= tx_free_space;
    end
  end

  // Chunk sequencing: data needs a prior start, and a start may not repeat.
  assign chunk_err = chunk_strobe & chunk_data_valid &
                     (chunk_start_valid ? (chunk_state == HSEF_IN_FRAME) : (chunk_state == HSEF_IDLE));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chunk_state <= HSEF_IDLE;
    end else if (chunk_strobe && chunk_data_valid) begin
      case (chunk_state)
        HSEF_IDLE: if (chunk_start_valid && !chunk_end_valid) chunk_state <= HSEF_IN_FRAME;
        HSEF_IN_FRAME: if (chunk_end_valid) chunk_state <= HSEF_IDLE;
        default: chunk_state <= HSEF_IDLE;
      endcase
    end
  end

  // Generic protocol: a new frame size while bytes remain is an error.
  assign fsize_err = tx_frame_size_reg_wr & (fsize_left != '0);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fsize_left <= '0;
    end else if (tx_frame_size_reg_wr) begin
      fsize_left <= tx_frame_size_reg_val;
    end else if (tx_data_wr && fsize_left != '0) begin
      fsize_left <= fsize_left - 1'b1;
    end
  end

  // Checks kept beside the logic.
  sequence s_overflow;
    ovf_evt;
  endsequence
  sequence s_mid_write;
    tx_wr && !tx_wr_sof;
  endsequence

  property p_rstdone_irq;
    @(posedge ref_clk) disable iff (rst) flags[`HSEF_BIT_RSTDONE] |=> !irq_out_n;
  endproperty
  a_rstdone_irq: assert property (p_rstdone_irq) else $error("reset-done did not pull irq low");

  property p_phy_after_reset;
    @(posedge ref_clk) disable iff (rst) !por_seen |-> ##2 phy_bit;
  endproperty
  a_phy_after_reset: assert property (p_phy_after_reset) else $error("phy bit not set after reset");

  property p_w1c_clear;
    @(posedge ref_clk) disable iff (rst)
      clr_vec[`HSEF_BIT_RSTDONE] && !reset_complete_evt |=> !flags[`HSEF_BIT_RSTDONE];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("reset-done not cleared by write one");

  property p_hdr_set;
    @(posedge ref_clk) disable iff (rst) hdr_bad_evt |=> flags[`HSEF_BIT_HDR];
  endproperty
  a_hdr_set: assert property (p_hdr_set) else $error("header error not flagged");

  property p_early_cs;
    @(posedge ref_clk) disable iff (rst) early_cs_evt |=> flags[`HSEF_BIT_LOF];
  endproperty
  a_early_cs: assert property (p_early_cs) else $error("early cs release not flagged");

  property p_cdp_lof;
    @(posedge ref_clk) disable iff (rst) set_vec[`HSEF_BIT_CDP] |=> flags[`HSEF_BIT_CDP] && flags[`HSEF_BIT_LOF];
  endproperty
  a_cdp_lof: assert property (p_cdp_lof) else $error("protection error did not set loss of frame");

  property p_underrun_gate;
    @(posedge ref_clk) disable iff (rst) $rose(flags[`HSEF_BIT_TXUND]) |-> $past(cut_through_en);
  endproperty
  a_underrun_gate: assert property (p_underrun_gate) else $error("underrun flagged without cut-through");

  property p_drop_frame;
    @(posedge ref_clk) disable iff (rst) s_overflow ##1 !(tx_wr && tx_wr_sof) ##1 s_mid_write |-> !tx_wr_accept;
  endproperty
  a_drop_frame: assert property (p_drop_frame) else $error("write accepted after overflow");

  property p_chunk_seq;
    @(posedge ref_clk) disable iff (rst)
      proto_chunk && chunk_strobe && chunk_data_valid && !chunk_start_valid && chunk_state == HSEF_IDLE
      |=> flags[`HSEF_BIT_TXSEQ];
  endproperty
  a_chunk_seq: assert property (p_chunk_seq) else $error("data without start not flagged");

  property p_sticky;
    @(posedge ref_clk) disable iff (rst) flags[`HSEF_BIT_RXOVF] && !clr_vec[`HSEF_BIT_RXOVF] |=> flags[`HSEF_BIT_RXOVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag dropped without clear");
endmodule : hsef_status
`default_nettype wire

// ---- rtl/hsef_map.svh ----
// Functional notes
// - PHY summary bit 7; host reads PHY status
// - PHY bit asserts after reset, masked default
// - Reset-done flag bit 6, resets to one
// - Reset-done flag drives unmaskable interrupt
// - Reset-done flag sets extended status indicator
// - Reset-done flag cleared only by writing one
// - Header parity error bit 5, chunk only
// - Early chip-select release sets bit 4
// - Protection error also sets bit 4; logic does so under chunk protocol only
// - Receive buffer overflow sets bit 3
// - Underrun bit 2 only with cut-through
// - Underrun stops current packet transmit
// - Report free space as credit and space
// - Overflow discards frame until next start
// - Transmit FIFO holds at least 4 kB
// - Chunk start/data sequencing errors set bit 0
// - Early frame-size write sets bit 0
// - Control data integrity failure sets bit 12; logic does so under chunk protocol only
// - Status register 32 bits, resets 0x40
`ifndef HSEF_MAP_SVH
`define HSEF_MAP_SVH
`define HSEF_ADDR_STATUS 6'h08
`define HSEF_ADDR_MASK 6'h0c
`define HSEF_STATUS_RESET 32'h00000040
`define HSEF_MASK_RESET 32'h0000103f
`define HSEF_W1C_BITS 13'h107f
`define HSEF_BIT_CDP 12
`define HSEF_BIT_PHY 7
`define HSEF_BIT_RSTDONE 6
`define HSEF_BIT_HDR 5
`define HSEF_BIT_LOF 4
`define HSEF_BIT_RXOVF 3
`define HSEF_BIT_TXUND 2
`define HSEF_BIT_TXOVF 1
`define HSEF_BIT_TXSEQ 0
`define HSEF_CMD_BITS 6'd8
`define HSEF_FRAME_BITS 6'd40
`define HSEF_TX_FIFO_BYTES 4096
`define HSEF_SPACE_W 13
`define HSEF_CREDIT_SHIFT 6
`define HSEF_FSIZE_W 14
`endif

// ---- rtl/hsef_pkg.sv ----
package hsef_pkg;
  // Transmit chunk sequencing state.
  typedef enum logic [0:0] {HSEF_IDLE, HSEF_IN_FRAME} hsef_chunk_state_type;
endpackage : hsef_pkg

// ---- rtl/hsef_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module hsef_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Two flops; the first is read only by the second.
  // Both load the pins' idle levels in reset, so no false edge follows its release.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : hsef_sync
`default_nettype wire

// ---- rtl/hsef_w1c_flag.sv ----
`timescale 1ns/1ns
`default_nettype none
module hsef_w1c_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic clr_wr,
  output logic flag
);
  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag <= RESET_VAL;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_wr) begin
      flag <= 1'b0;
    end
  end
endmodule : hsef_w1c_flag
`default_nettype wire

// ---- bench/hsef_spi_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// SPI host model in mode 0; its clock stands still and low between frames.
module hsef_spi_host (
  input wire logic ref_clk,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Shifts nbits of a frame MSB first; fewer than 40 releases select early.
  task automatic xfer(input logic [39:0] frame, input int nbits, output logic [31:0] rd);
    rd = 32'h0;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      spi_mosi = frame[39-k];
      repeat (4) @(negedge ref_clk);
      spi_sclk = 1'b1;
      if (k >= 8) rd[39-k] = spi_miso;
      repeat (4) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    // A released line shows the inverse, so a stale bit never looks driven.
    spi_mosi = ~spi_mosi;
    repeat (4) @(negedge ref_clk);
    spi_cs_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask : xfer
endmodule : hsef_spi_host
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hsef_map.svh"
module tb;
  import hsef_pkg::*;
  logic ref_clk, rst, sclk, cs_n, mosi, miso, miso_oe, proto_chunk, cut_through_en;
  logic phy_irq_src, phy_irq_ack, tx_fifo_full, tx_wr_accept, tx_frame_discard, tx_abort;
  logic extended_status_ind, irq_out_n;
  logic [3:0] evt, ck, tx;
  logic [`HSEF_FSIZE_W-1:0] fsz;
  logic [`HSEF_SPACE_W-1:0] sp, tx_space;
  logic [7:0] tx_credit_field;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 50;
  hsef_status uut (.ref_clk(ref_clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .proto_chunk(proto_chunk), .cut_through_en(cut_through_en),
    .phy_irq_src(phy_irq_src), .phy_irq_ack(phy_irq_ack), .reset_complete_evt(evt[3]),
    .ctrl_protect_fail(evt[0]), .rx_buf_overflow_evt(evt[1]), .tx_underrun_evt(evt[2]),
    .chunk_strobe(ck[3]), .chunk_data_valid(ck[2]), .chunk_start_valid(ck[1]), .chunk_end_valid(ck[0]),
    .tx_frame_size_reg_wr(tx[3]), .tx_frame_size_reg_val(fsz), .tx_data_wr(tx[2]), .tx_wr(tx[1]), .tx_wr_sof(tx[0]),
    .tx_fifo_full(tx_fifo_full), .tx_free_space(sp), .tx_wr_accept(tx_wr_accept),
    .tx_frame_discard(tx_frame_discard), .tx_abort(tx_abort), .tx_credit_field(tx_credit_field),
    .tx_space(tx_space), .extended_status_ind(extended_status_ind), .irq_out_n(irq_out_n));
  // A released data line shows the inverse of its last bit, so a stale value never looks driven.
  hsef_spi_host host (.ref_clk(ref_clk), .spi_miso(miso_oe ? miso : ~miso), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi));
  // Free-running 50 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Comparison tasks count every check and report mismatches at once.
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask : chk_pin
  task automatic summarize;
    $display("Comparisons %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Command byte with odd parity when good is set, even otherwise.
  function automatic logic [7:0] mk_cmd(input logic w, input logic [5:0] a, input logic good);
    mk_cmd = {w, ~(^{w, a}) ^ ~good, a};
  endfunction : mk_cmd
  // Status value expected after one pulse of each event input.
  function automatic logic [31:0] exp_evt(input int k, input logic ct);
    case (k)
      0: exp_evt = 32'h00001010;
      1: exp_evt = 32'h00000008;
      2: exp_evt = ct ? 32'h00000004 : 32'h0;
      default: exp_evt = 32'h00000040;
    endcase
  endfunction : exp_evt
  task automatic io(input logic w, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    host.xfer({mk_cmd(w, a, 1'b1), wd}, 40, rd);
  endtask : io
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic [31:0] d;
    io(1'b1, a, v, d);
  endtask : wr
  task automatic st(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    io(1'b0, a, 32'h0, d);
    chk_reg(d, e);
  endtask : st
  task automatic chunk(input logic [2:0] q);
    @(negedge ref_clk) ck = {1'b1, q};
    @(negedge ref_clk) ck = 4'h0;
  endtask : chunk
  // One transmit-side pulse; the combinational answers are looked at while it stands.
  task automatic txp(input logic [3:0] v, input logic acc, input logic dis);
    @(negedge ref_clk) tx = v;
    #1 chk_pin(tx_wr_accept, acc);
    chk_pin(tx_frame_discard, dis);
    @(negedge ref_clk) tx = 4'h0;
  endtask : txp
  // Watchdog: a hang counts as a mismatch and ends the run.
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [31:0] d, e;
    int nb;
    {rst, proto_chunk, cut_through_en, phy_irq_src, phy_irq_ack, tx_fifo_full} = 6'b110000;
    {evt, ck, tx, fsz, sp} = '0;
    repeat (4) @(negedge ref_clk);
    chk_pin(miso_oe, 1'b0);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_pin(irq_out_n, 1'b0);
    chk_pin(extended_status_ind, 1'b1);
    st(`HSEF_ADDR_STATUS, 32'hc0);
    st(`HSEF_ADDR_MASK, 32'h103f);
    wr(`HSEF_ADDR_STATUS, 32'h0);
    st(`HSEF_ADDR_STATUS, 32'hc0);
    wr(`HSEF_ADDR_STATUS, 32'h80);
    st(`HSEF_ADDR_STATUS, 32'hc0);
    @(negedge ref_clk) phy_irq_ack = 1'b1;
    @(negedge ref_clk) phy_irq_ack = 1'b0;
    st(`HSEF_ADDR_STATUS, 32'h40);
    wr(`HSEF_ADDR_STATUS, 32'h40);
    st(`HSEF_ADDR_STATUS, 32'h0);
    chk_pin(extended_status_ind, 1'b0);
    chk_pin(irq_out_n, 1'b1);
    phy_irq_src = 1'b1;
    st(`HSEF_ADDR_STATUS, 32'h80);
    chk_pin(irq_out_n, 1'b1);
    phy_irq_src = 1'b0;
    // Each event with cut-through off and on; flags must stick until cleared.
    for (int k = 0; k < 4; k++) begin
      for (int ct = 0; ct < 2; ct++) begin
        cut_through_en = ct[0];
        e = exp_evt(k, ct[0]);
        @(negedge ref_clk) evt = 4'h1 << k;
        #1 chk_pin(tx_abort, k == 2 && ct == 1);
        @(negedge ref_clk) evt = 4'h0;
        repeat (3) @(negedge ref_clk);
        chk_pin(irq_out_n, e == 32'h0);
        st(`HSEF_ADDR_STATUS, e);
        wr(`HSEF_ADDR_STATUS, e);
        st(`HSEF_ADDR_STATUS, 32'h0);
      end
    end
    // Bad parity counts only under the chunk protocol.
    host.xfer({mk_cmd(1'b0, `HSEF_ADDR_STATUS, 1'b0), 32'h0}, 40, d);
    st(`HSEF_ADDR_STATUS, 32'h20);
    wr(`HSEF_ADDR_STATUS, 32'h20);
    proto_chunk = 1'b0;
    host.xfer({mk_cmd(1'b0, `HSEF_ADDR_STATUS, 1'b0), 32'h0}, 40, d);
    st(`HSEF_ADDR_STATUS, 32'h0);
    proto_chunk = 1'b1;
    nb = 1 + ($unsigned($random(seed)) % 39);
    host.xfer({mk_cmd(1'b0, `HSEF_ADDR_STATUS, 1'b1), 32'h0}, nb, d);
    st(`HSEF_ADDR_STATUS, 32'h10);
    wr(`HSEF_ADDR_STATUS, 32'h10);
    chunk(3'b100);
    st(`HSEF_ADDR_STATUS, 32'h1);
    wr(`HSEF_ADDR_STATUS, 32'h1);
    chunk(3'b010);
    chunk(3'b110);
    chunk(3'b110);
    st(`HSEF_ADDR_STATUS, 32'h1);
    wr(`HSEF_ADDR_STATUS, 32'h1);
    chunk(3'b001);
    chunk(3'b010);
    chunk(3'b100);
    chunk(3'b101);
    st(`HSEF_ADDR_STATUS, 32'h0);
    // Generic protocol: a new size is legal only once the previous frame is written.
    proto_chunk = 1'b0;
    fsz = 14'h1;
    txp(4'h8, 1'b0, 1'b0);
    txp(4'h4, 1'b0, 1'b0);
    fsz = 14'h2;
    txp(4'h8, 1'b0, 1'b0);
    txp(4'h4, 1'b0, 1'b0);
    st(`HSEF_ADDR_STATUS, 32'h0);
    txp(4'h8, 1'b0, 1'b0);
    st(`HSEF_ADDR_STATUS, 32'h1);
    wr(`HSEF_ADDR_STATUS, 32'h1);
    // The host writes into a full FIFO on purpose to force an overflow.
    tx_fifo_full = 1'b1;
    txp(4'h2, 1'b0, 1'b1);
    tx_fifo_full = 1'b0;
    txp(4'h2, 1'b0, 1'b0);
    txp(4'h3, 1'b1, 1'b0);
    txp(4'h2, 1'b1, 1'b0);
    st(`HSEF_ADDR_STATUS, 32'h2);
    wr(`HSEF_ADDR_STATUS, 32'h2);
    // Free space with corners at empty and at a full 4 kB.
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk) sp = (i == 0) ? 13'h0 : (i == 1) ? 13'h1000 : 13'($random(seed));
      repeat (2) @(negedge ref_clk);
      chk_reg({24'h0, tx_credit_field}, {25'h0, sp[12:6]});
      chk_reg({19'h0, tx_space}, {19'h0, sp});
    end
    // Random writes that touch no clearable bit, and unmapped places.
    for (int i = 0; i < 3; i++) begin
      wr(`HSEF_ADDR_STATUS, $random(seed) & ~32'h107f);
      st(`HSEF_ADDR_STATUS, 32'h0);
      wr(6'h10 + 6'($unsigned($random(seed)) % 48), 32'hffffffff);
      st(6'h10 + 6'($unsigned($random(seed)) % 48), 32'h0);
    end
    summarize();
  end
endmodule : tb
`default_nettype wire
